// File: itr_master.sv
// Bus master end of the two-wire link with its read-data FIFO.
module itr_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic full;
    logic empty;

    assign empty = (wr_q == rd_q);
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (i_in_valid && !full)
            begin
                mem_q[wr_q[AW-1:0]] <= i_in_data;
                wr_q <= wr_q + (AW + 1)'(1);
            end
            if (i_out_ready && !empty)
            begin
                rd_q <= rd_q + (AW + 1)'(1);
            end
        end
    end

    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = mem_q[rd_q[AW-1:0]];
endmodule

module itr_master (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    itr_link_if.host lnk,
    input wire logic i_cmd_valid,
    input wire logic [1:0] i_cmd_kind,
    input wire logic [7:0] i_cmd_reg,
    input wire logic [7:0] i_cmd_data,
    input wire logic [7:0] i_cmd_len,
    output logic o_cmd_ready,
    output logic o_nack,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [7:0] o_rd_data
);
    itr_pkg::itr_hstate_e state_q;
    itr_pkg::itr_kind_e kind_q;
    logic [2:0] div_q;
    logic [1:0] q_q;
    logic [3:0] bit_q;
    logic [1:0] step_q;
    logic [7:0] sh_q;
    logic [7:0] rx_q;
    logic [7:0] reg_q;
    logic [7:0] data_q;
    logic [7:0] left_q;
    logic [1:0] sda_sync_q;
    logic scl_q;
    logic sda_oe_q;
    logic ready_q;
    logic nack_q;
    logic push_q;
    logic fifo_rdy;
    logic stall;
    logic tick;
    logic step_end;
    logic scl_d;
    logic oe_d;

    function automatic logic [7:0] tx_byte(input itr_pkg::itr_kind_e k, input logic [1:0] s,
                                           input logic [7:0] r, input logic [7:0] d);
        if (s == 2'h0)
        begin
            return {itr_pkg::DEV_ADDR, k == itr_pkg::K_CUR};
        end
        else if (s == 2'h1)
        begin
            return r;
        end
        else
        begin
            return (k == itr_pkg::K_WRITE) ? d : {itr_pkg::DEV_ADDR, 1'b1};
        end
    endfunction

    assign stall = (state_q == itr_pkg::H_READ) && (bit_q == 4'h0) && (q_q == 2'h0) && !fifo_rdy;
    assign tick = (div_q == itr_pkg::QTR_LAST) && !stall;
    assign step_end = tick && (q_q == 2'h3);

    always_comb
    begin
        scl_d = 1'b1;
        oe_d = 1'b0;
        case (state_q)
            itr_pkg::H_START:
            begin
                scl_d = (q_q != 2'h0);
                oe_d = q_q[1];
            end
            itr_pkg::H_STOP:
            begin
                scl_d = (q_q != 2'h0);
                oe_d = !q_q[1];
            end
            itr_pkg::H_BYTE:
            begin
                scl_d = (q_q == 2'h1) || (q_q == 2'h2);
                oe_d = (bit_q != itr_pkg::BIT_ACK) && !sh_q[7];
            end
            itr_pkg::H_READ:
            begin
                scl_d = (q_q == 2'h1) || (q_q == 2'h2);
                oe_d = (bit_q == itr_pkg::BIT_ACK) && (left_q > 8'h01);
            end
            default:
            begin
                scl_d = 1'b1;
                oe_d = 1'b0;
            end
        endcase
    end

    // Clock divider, line drivers and data sampling; data moves mid-quarter, away from clock edges.
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_q <= 3'h0;
            q_q <= 2'h0;
            scl_q <= 1'b1;
            sda_oe_q <= 1'b0;
            sda_sync_q <= 2'h3;
            rx_q <= 8'h00;
        end
        else
        begin
            sda_sync_q <= {sda_sync_q[0], lnk.sda};
            scl_q <= scl_d;
            if (div_q == itr_pkg::QTR_MID)
            begin
                sda_oe_q <= oe_d;
            end
            if (state_q == itr_pkg::H_IDLE || stall || tick)
            begin
                div_q <= 3'h0;
            end
            else
            begin
                div_q <= div_q + 3'h1;
            end
            if (state_q == itr_pkg::H_IDLE)
            begin
                q_q <= 2'h0;
            end
            else if (tick)
            begin
                q_q <= q_q + 2'h1;
            end
            if (tick && q_q == 2'h2)
            begin
                rx_q <= {rx_q[6:0], sda_sync_q[1]};
            end
        end
    end

    // Transaction sequencer.
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= itr_pkg::H_IDLE;
            kind_q <= itr_pkg::K_WRITE;
            bit_q <= 4'h0;
            step_q <= 2'h0;
            sh_q <= 8'h00;
            reg_q <= 8'h00;
            data_q <= 8'h00;
            left_q <= 8'h00;
            ready_q <= 1'b1;
            nack_q <= 1'b0;
            push_q <= 1'b0;
        end
        else
        begin
            push_q <= 1'b0;
            case (state_q)
                itr_pkg::H_IDLE:
                begin
                    if (i_cmd_valid && ready_q)
                    begin
                        kind_q <= itr_pkg::itr_kind_e'(i_cmd_kind);
                        reg_q <= i_cmd_reg;
                        data_q <= i_cmd_data;
                        left_q <= (i_cmd_len == 8'h00) ? 8'h01 : i_cmd_len;
                        step_q <= 2'h0;
                        nack_q <= 1'b0;
                        ready_q <= 1'b0;
                        state_q <= itr_pkg::H_START;
                    end
                end
                itr_pkg::H_START:
                begin
                    if (step_end)
                    begin
                        state_q <= itr_pkg::H_BYTE;
                        bit_q <= 4'h0;
                        sh_q <= tx_byte(kind_q, step_q, reg_q, data_q);
                    end
                end
                itr_pkg::H_BYTE:
                begin
                    if (step_end && bit_q != itr_pkg::BIT_ACK)
                    begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                    end
                    else if (step_end)
                    begin
                        bit_q <= 4'h0;
                        if (rx_q[0])
                        begin
                            nack_q <= 1'b1;
                            state_q <= itr_pkg::H_STOP;
                        end
                        else if (kind_q == itr_pkg::K_CUR || step_q == 2'h2 && kind_q == itr_pkg::K_RAND)
                        begin
                            state_q <= itr_pkg::H_READ;
                        end
                        else if (kind_q == itr_pkg::K_RAND && step_q == 2'h1)
                        begin
                            step_q <= 2'h2;
                            state_q <= itr_pkg::H_START;
                        end
                        else if (step_q == 2'h2 || kind_q != itr_pkg::K_WRITE && kind_q != itr_pkg::K_RAND)
                        begin
                            state_q <= itr_pkg::H_STOP;
                        end
                        else
                        begin
                            step_q <= step_q + 2'h1;
                            sh_q <= tx_byte(kind_q, step_q + 2'h1, reg_q, data_q);
                        end
                    end
                end
                itr_pkg::H_READ:
                begin
                    if (step_end && bit_q == 4'h7)
                    begin
                        push_q <= 1'b1;
                    end
                    if (step_end && bit_q != itr_pkg::BIT_ACK)
                    begin
                        bit_q <= bit_q + 4'h1;
                    end
                    else if (step_end)
                    begin
                        bit_q <= 4'h0;
                        if (left_q > 8'h01)
                        begin
                            left_q <= left_q - 8'h01;
                        end
                        else
                        begin
                            state_q <= itr_pkg::H_STOP;
                        end
                    end
                end
                itr_pkg::H_STOP:
                begin
                    if (step_end)
                    begin
                        state_q <= itr_pkg::H_IDLE;
                        ready_q <= 1'b1;
                    end
                end
                default:
                begin
                    state_q <= itr_pkg::H_IDLE;
                    ready_q <= 1'b1;
                end
            endcase
        end
    end

    itr_fifo #(
        .W(itr_pkg::FIFO_W),
        .D(itr_pkg::FIFO_D)
    ) u_fifo (
        .i_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_in_valid(push_q),
        .o_in_ready(fifo_rdy),
        .i_in_data(rx_q),
        .o_out_valid(o_rd_valid),
        .i_out_ready(i_rd_ready),
        .o_out_data(o_rd_data)
    );

    assign lnk.scl = scl_q;
    assign lnk.host_sda_o = 1'b0;
    assign lnk.host_sda_oe = sda_oe_q;
    assign o_cmd_ready = ready_q;
    assign o_nack = nack_q;
endmodule

// File: itr_pkg.sv
// Shared constants and types for the two-wire register read link.
package itr_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h69;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int NUM_REGS = 256;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCL_MIN_PERIOD_NS = 2500;
    localparam int QTR_CYC = (SCL_MIN_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    localparam logic [2:0] QTR_LAST = 3'(QTR_CYC - 1);
    localparam logic [2:0] QTR_MID = 3'(QTR_CYC / 2);
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 16;
    localparam logic [3:0] BIT_ACK = 4'h8;

    typedef enum logic [1:0]
    {
        K_WRITE = 2'h0,
        K_CUR = 2'h1,
        K_RAND = 2'h2
    } itr_kind_e;

    typedef enum logic [2:0]
    {
        D_IDLE = 3'h0,
        D_ADDR = 3'h1,
        D_REG = 3'h3,
        D_WDATA = 3'h2,
        D_RDATA = 3'h6,
        D_WAIT = 3'h7
    } itr_dstate_e;

    typedef enum logic [2:0]
    {
        H_IDLE = 3'h0,
        H_START = 3'h1,
        H_BYTE = 3'h3,
        H_READ = 3'h2,
        H_STOP = 3'h6
    } itr_hstate_e;
endpackage

// File: itr_link_if.sv
// Two-wire link between the bus master and the register target.
interface itr_link_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    wire sda;

    // Open-drain wired-AND of both drivers with an implied pull-up.
    assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

    modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
    modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

// File: itr_target.sv
// Register target end of the two-wire link with 256 volatile registers.
// Functional notes
// - Read starts like write, direction bit one.
// - Pointer holds last accessed address plus one.
// - Own address with read: acknowledge, send byte.
// - Unacknowledged byte then STOP ends the read.
// - Write with address only, restart: pointer loaded.
// - Master resends address with read after restart.
// - Master acknowledge advances pointer, sends next byte.
// - Pointer wraps from FFH to 00H.
// - Answer only bus address 69H plus direction.
// - Write: register address, then data, auto-increment.
// - Acknowledge received bytes by holding data low.
module itr_target (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    itr_link_if.device lnk,
    output logic o_evt_valid,
    output logic o_evt_read,
    output logic [7:0] o_evt_addr,
    output logic [7:0] o_evt_data
);
    itr_pkg::itr_dstate_e state_q;
    logic start_tog_q;
    logic start_seen_q;
    logic bit_q;
    logic [3:0] cnt_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic rw_q;
    logic sda_oe_q;
    logic [7:0] regs_q [itr_pkg::NUM_REGS];
    logic [7:0] rx_byte;
    logic [7:0] cur_reg;
    logic evt_tog_q;
    logic evt_read_q;
    logic [7:0] evt_addr_q;
    logic [7:0] evt_data_q;
    logic [2:0] evt_sync_q;
    logic evt_valid_q;
    logic evt_read_r_q;
    logic [7:0] evt_addr_r_q;
    logic [7:0] evt_data_r_q;

    assign rx_byte = {rx_q[6:0], bit_q};
    assign cur_reg = regs_q[ptr_q];

    // A falling data line while the clock is high marks a START.
    always_ff @(negedge lnk.sda or posedge i_rst)
    begin
        if (i_rst)
        begin
            start_tog_q <= 1'b0;
        end
        else if (lnk.scl)
        begin
            start_tog_q <= ~start_tog_q;
        end
    end

    // Data is taken on the rising clock edge, while it is stable.
    always_ff @(posedge lnk.scl or posedge i_rst)
    begin
        if (i_rst)
        begin
            bit_q <= 1'b1;
        end
        else
        begin
            bit_q <= lnk.sda;
        end
    end

    // Protocol engine; it acts and drives the line on the falling clock edge.
    always_ff @(negedge lnk.scl or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= itr_pkg::D_IDLE;
            start_seen_q <= 1'b0;
            cnt_q <= 4'h0;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            sda_oe_q <= 1'b0;
            evt_tog_q <= 1'b0;
            evt_read_q <= 1'b0;
            evt_addr_q <= 8'h00;
            evt_data_q <= 8'h00;
            for (int i = 0; i < itr_pkg::NUM_REGS; i++)
            begin
                regs_q[i] <= itr_pkg::REG_RESET;
            end
        end
        else if (start_seen_q != start_tog_q)
        begin
            start_seen_q <= start_tog_q;
            state_q <= itr_pkg::D_ADDR;
            cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                itr_pkg::D_ADDR, itr_pkg::D_REG, itr_pkg::D_WDATA:
                begin
                    if (cnt_q != itr_pkg::BIT_ACK)
                    begin
                        rx_q <= rx_byte;
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'h7)
                        begin
                            if (state_q != itr_pkg::D_ADDR)
                            begin
                                sda_oe_q <= 1'b1;
                            end
                            else if (rx_byte[7:1] == itr_pkg::DEV_ADDR)
                            begin
                                sda_oe_q <= 1'b1;
                                rw_q <= rx_byte[0];
                            end
                        end
                    end
                    else
                    begin
                        cnt_q <= 4'h0;
                        sda_oe_q <= 1'b0;
                        if (state_q == itr_pkg::D_ADDR)
                        begin
                            if (rx_q[7:1] != itr_pkg::DEV_ADDR)
                            begin
                                state_q <= itr_pkg::D_IDLE;
                            end
                            else if (rw_q)
                            begin
                                state_q <= itr_pkg::D_RDATA;
                                tx_q <= {cur_reg[6:0], 1'b0};
                                sda_oe_q <= ~cur_reg[7];
                                ptr_q <= ptr_q + 8'h01;
                                evt_tog_q <= ~evt_tog_q;
                                evt_read_q <= 1'b1;
                                evt_addr_q <= ptr_q;
                                evt_data_q <= cur_reg;
                            end
                            else
                            begin
                                state_q <= itr_pkg::D_REG;
                            end
                        end
                        else if (state_q == itr_pkg::D_REG)
                        begin
                            ptr_q <= rx_q;
                            state_q <= itr_pkg::D_WDATA;
                        end
                        else
                        begin
                            regs_q[ptr_q] <= rx_q;
                            ptr_q <= ptr_q + 8'h01;
                            evt_tog_q <= ~evt_tog_q;
                            evt_read_q <= 1'b0;
                            evt_addr_q <= ptr_q;
                            evt_data_q <= rx_q;
                        end
                    end
                end
                itr_pkg::D_RDATA:
                begin
                    if (cnt_q < 4'h7)
                    begin
                        sda_oe_q <= ~tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    else if (cnt_q == 4'h7)
                    begin
                        sda_oe_q <= 1'b0;
                        cnt_q <= itr_pkg::BIT_ACK;
                    end
                    else if (!bit_q)
                    begin
                        cnt_q <= 4'h0;
                        tx_q <= {cur_reg[6:0], 1'b0};
                        sda_oe_q <= ~cur_reg[7];
                        ptr_q <= ptr_q + 8'h01;
                        evt_tog_q <= ~evt_tog_q;
                        evt_read_q <= 1'b1;
                        evt_addr_q <= ptr_q;
                        evt_data_q <= cur_reg;
                    end
                    else
                    begin
                        state_q <= itr_pkg::D_WAIT;
                        sda_oe_q <= 1'b0;
                        cnt_q <= 4'h0;
                    end
                end
                itr_pkg::D_WAIT, itr_pkg::D_IDLE:
                begin
                    sda_oe_q <= 1'b0;
                    cnt_q <= 4'h0;
                end
                default:
                begin
                    state_q <= itr_pkg::D_IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    assign lnk.dev_sda_o = 1'b0;
    assign lnk.dev_sda_oe = sda_oe_q;

    // Access events cross to the reference clock by a toggle; payload is held until the next event.
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            evt_sync_q <= 3'h0;
            evt_valid_q <= 1'b0;
            evt_read_r_q <= 1'b0;
            evt_addr_r_q <= 8'h00;
            evt_data_r_q <= 8'h00;
        end
        else
        begin
            evt_sync_q <= {evt_sync_q[1:0], evt_tog_q};
            evt_valid_q <= evt_sync_q[2] ^ evt_sync_q[1];
            if (evt_sync_q[2] ^ evt_sync_q[1])
            begin
                evt_read_r_q <= evt_read_q;
                evt_addr_r_q <= evt_addr_q;
                evt_data_r_q <= evt_data_q;
            end
        end
    end

    assign o_evt_valid = evt_valid_q;
    assign o_evt_read = evt_read_r_q;
    assign o_evt_addr = evt_addr_r_q;
    assign o_evt_data = evt_data_r_q;
endmodule

// File: itr_link_properties.sv
// Assertions on the two-wire link between the bus master and the register target.
module itr_link_properties (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic scl,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic sda
);
    logic scl_q, sda_q, first_q, rd_q, nk_q, rise, start;
    logic [3:0] bit_q;
    logic [7:0] byte_q;
    assign rise = scl && !scl_q;
    assign start = scl && scl_q && sda_q && !sda;

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            {scl_q, sda_q} <= 2'h3;
        else
            {scl_q, sda_q} <= {scl, sda};
    end

    // Tracks the bit position, the first byte after a start and the transfer direction.
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            {bit_q, first_q, rd_q, nk_q, byte_q} <= 15'h0;
        else if (start)
            {bit_q, first_q, rd_q, nk_q} <= 7'h04;
        else if (rise && bit_q == 4'h8)
        begin
            bit_q <= 4'h0;
            first_q <= 1'b0;
            rd_q <= first_q ? byte_q[0] : rd_q;
            nk_q <= nk_q || (rd_q && !first_q && sda);
        end
        else if (rise)
        begin
            bit_q <= bit_q + 4'h1;
            byte_q <= {byte_q[6:0], sda};
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    ack_drive_a:
        assert property (rise && bit_q == 4'h8 && (first_q || !rd_q) |-> (dev_sda_oe && !sda)[*8])
        else $error("target did not hold the acknowledge");
    read_ack_free_a:
        assert property (rise && bit_q == 4'h8 && rd_q && !first_q |-> !dev_sda_oe)
        else $error("target drove the line in the master acknowledge");
    nack_quiet_a:
        assert property (nk_q |-> !dev_sda_oe)
        else $error("target drove the line after a not-acknowledge");
    dev_hold_a:
        assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("target changed the data line while the clock was high");
    addr_listen_a:
        assert property (first_q && bit_q < 4'h8 |-> !dev_sda_oe)
        else $error("target drove the line during the address byte");
    host_release_a:
        assert property (rd_q && !first_q && bit_q != 4'h0 && bit_q < 4'h8 && !nk_q |-> !host_sda_oe)
        else $error("master drove the line during read data");
    open_drain_a:
        assert property (dev_sda_oe || host_sda_oe |-> !(dev_sda_oe && dev_sda_o) && !(host_sda_oe && host_sda_o))
        else $error("a driver pushed the line high");
    start_hold_a:
        assert property (start |-> scl[*6])
        else $error("clock fell too soon after a start");
    scl_high_a:
        assert property ($rose(scl) |-> scl[*6])
        else $error("clock high period too short");
endmodule

// File: i2c_target_register_read_tb.sv
// Self-checking bench for the two-wire register read link.
module i2c_target_register_read_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b0;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_kind = 2'h0;
    logic [7:0] cmd_reg = 8'h00;
    logic [7:0] cmd_data = 8'h00;
    logic [7:0] cmd_len = 8'h00;
    logic rd_ready = 1'b0;
    logic stall = 1'b0;
    logic cmd_ready, nack, rd_valid, evt_valid, evt_read;
    logic [7:0] rd_data, evt_addr, evt_data;
    logic [7:0] mem [256];
    logic [7:0] ptr = 8'h00;
    logic [7:0] rdq [$];
    logic [16:0] evq [$];
    logic [31:0] seed = 32'h0000b65e;
    int fail_count = 0;
    int comparisons = 0;

    itr_link_if lnk ();
    itr_master u_itr_master (.i_ref_clk(clk), .i_rst(rst), .lnk(lnk), .i_cmd_valid(cmd_valid),
        .i_cmd_kind(cmd_kind), .i_cmd_reg(cmd_reg), .i_cmd_data(cmd_data), .i_cmd_len(cmd_len),
        .o_cmd_ready(cmd_ready), .o_nack(nack), .o_rd_valid(rd_valid), .i_rd_ready(rd_ready),
        .o_rd_data(rd_data));
    itr_target u_itr_target (.i_ref_clk(clk), .i_rst(rst), .lnk(lnk), .o_evt_valid(evt_valid),
        .o_evt_read(evt_read), .o_evt_addr(evt_addr), .o_evt_data(evt_data));
    itr_link_properties u_itr_link_properties (.i_ref_clk(clk), .i_rst(rst), .scl(lnk.scl),
        .host_sda_o(lnk.host_sda_o), .host_sda_oe(lnk.host_sda_oe), .dev_sda_o(lnk.dev_sda_o),
        .dev_sda_oe(lnk.dev_sda_oe), .sda(lnk.sda));

    always #50 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Notes the expected bytes and events, then runs one command to completion.
    task automatic cmd(input logic [1:0] k, input logic [7:0] r, input logic [7:0] d, input logic [7:0] n);
        int w;
        if (k == itr_pkg::K_WRITE)
        begin
            mem[r] = d;
            evq.push_back({1'b0, r, d});
            ptr = r + 8'h01;
        end
        else
        begin
            if (k == itr_pkg::K_RAND)
                ptr = r;
            for (w = 0; w < ((n == 8'h00) ? 1 : int'(n)); w++)
            begin
                rdq.push_back(mem[ptr]);
                evq.push_back({1'b1, ptr, mem[ptr]});
                ptr++;
            end
        end
        @(negedge clk);
        {cmd_kind, cmd_reg, cmd_data, cmd_len, cmd_valid} = {k, r, d, n, 1'b1};
        @(posedge clk);
        while (cmd_ready !== 1'b1)
            @(posedge clk);
        @(negedge clk);
        cmd_valid = 1'b0;
        while (cmd_ready !== 1'b1 || rdq.size() > 0)
            @(negedge clk);
        repeat (8) @(negedge clk);
        chk({16'h0, nack}, 17'h0);
    endtask

    always @(posedge clk)
    begin
        if (rd_valid === 1'b1 && rd_ready === 1'b1)
            chk({9'h0, rd_data}, {9'h0, rdq.pop_front()});
        if (evt_valid === 1'b1)
            chk({evt_read, evt_addr, evt_data}, evq.pop_front());
    end

    always @(negedge clk)
        rd_ready <= !stall && ((rnd() & 32'h3) != 32'h0);

    initial
    begin
        foreach (mem[j])
            mem[j] = itr_pkg::REG_RESET;
        #1 rst = 1'b1;
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        cmd(itr_pkg::K_CUR, 8'h00, 8'h00, 8'h01);
        $display("test reset read done");
        for (int i = 0; i < 8; i++)
            cmd(itr_pkg::K_WRITE, 8'hfc + 8'(i), 8'(rnd()), 8'h00);
        $display("test writes done");
        cmd(itr_pkg::K_RAND, 8'h01, 8'h00, 8'h01);
        cmd(itr_pkg::K_CUR, 8'h00, 8'h00, 8'h02);
        $display("test random and current reads done");
        cmd(itr_pkg::K_RAND, 8'hfe, 8'h00, 8'h04);
        cmd(itr_pkg::K_CUR, 8'h00, 8'h00, 8'h00);
        $display("test wrap done");
        stall = 1'b1;
        fork
        begin
            repeat (6000) @(negedge clk);
            chk({15'h0, lnk.scl, rd_valid}, 17'h1);
            stall = 1'b0;
        end
        join_none
        cmd(itr_pkg::K_RAND, 8'hf8, 8'h00, 8'h14);
        $display("test buffer stall done");
        chk(17'(rdq.size() + evq.size()), 17'h0);
        end_sim();
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        fail_count++;
        end_sim();
    end
endmodule
